// [src/sar_adc_map.svh]
// Purpose: constants for the SAR converter control and serial readout
// Assumes: clk_in at 50 MHz stands in for the internal conversion oscillator
// Notes: all times in ns, cycle counts derived from them
// Behaviour
// - chain select low: shared pin is active-low enable of serial output.
// - chain select high: shared pin is serial input from upstream converter.
// - rising convert strobe wakes device and starts a conversion; host drives it.
// - busy rises when conversion begins, falls when it completes.
// - while output enabled, each serial clock rise presents next bit, MSB first.
// - result is unsigned straight binary.
// - acquisition phase alternates with 18-bit successive-approximation conversion phase.
// - result word has 2^18 codes, 18 bits wide.
// - at conversion end the 18-bit code is loaded for serial transfer.
// - conversion time set by internal timer, independent of serial clock.
// - result readable within the same cycle, no pipeline latency; here it waits in the fifo behind any unread earlier word.
// - device powers down between conversions, wakes on next strobe.
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
// ==========================================
// word and timing
`define SAR_BITS 18
`define CLK_PERIOD_NS 20
`define CONV_MIN_NS 460
`define CONV_MAX_NS 527
`define CYCLE_MIN_NS 1000
`define POR_WAIT_NS 20000
// least time rounds up to whole cycles
`define CONV_CYCLES ((`CONV_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 8
`define SYNC_WIDTH 4
`endif

// [src/sar_adc_pkg.sv]
// Purpose: shared types for the SAR converter control
// Assumes: nothing
// Notes: states of the conversion sequencer
package sar_adc_pkg;
    typedef enum logic [1:0] {
        ST_ACQ = 2'b00,
        ST_CONV = 2'b01,
        ST_WAIT = 2'b10
    } conv_state_e;
endpackage

// [src/sar_adc_readout.sv]
// Purpose: conversion sequencing, result buffering and serial readout
// Assumes: comparator_in is registered on clk_in by the analog front end
// Notes: pin inputs pass a two-flop synchroniser before any use
`timescale 1ns/1ps
`include "sar_adc_map.svh"

// ==========================================
// two-flop synchroniser bank
module sync_bank #(
    parameter int W = 4
) (
    input wire logic clk_in, // core clock
    input wire logic resetn_in, // async reset, low
    input wire logic [W-1:0] d_in, // async levels
    output logic [W-1:0] q_out // synchronised levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
        end
    end

    assign q_out = s2_q;
endmodule

// ==========================================
// result fifo
module result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_in, // core clock
    input wire logic resetn_in, // async reset, low
    input wire logic wr_valid_in, // push request
    output logic wr_ready_out, // room for a word
    input wire logic [WIDTH-1:0] wr_data_in, // pushed word
    output logic rd_valid_out, // word available
    input wire logic rd_ready_in, // pop request
    output logic [WIDTH-1:0] rd_data_out // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    wire push = wr_valid_in && wr_ready_out;
    wire pop = rd_valid_out && rd_ready_in;
    wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);

    // flags from pointers, extra bit tells full from empty
    assign wr_ready_out = !full;
    assign rd_valid_out = wp_q != rp_q;
    assign rd_data_out = mem[rp_q[AW-1:0]];

    // storage has no reset, only pointers do
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= wr_data_in;
        end
    end

    // pointers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule

// ==========================================
// top: converter control and serial readout
module sar_adc_readout #(
    parameter int BITS = `SAR_BITS,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_in, // core clock, 50 MHz
    input wire logic resetn_in, // power-on reset, low
    input wire logic convert_strobe_in, // conversion start pin
    input wire logic chain_select_in, // mode pin
    input wire logic read_enable_or_chain_input_in, // enable or chain data
    input wire logic sclk_in, // host serial clock
    input wire logic comparator_in, // high: input above trial
    output logic busy_out, // conversion running
    output logic sdo_out, // serial data
    output logic sdo_oe_out, // serial data driven
    output logic [BITS-1:0] sampling_cap_dac_out, // trial code
    output logic sample_out, // acquisition switch closed
    output logic powered_up_out // core powered
);
    localparam logic [4:0] CONV_LEN = 5'(`CONV_CYCLES);
    localparam logic [4:0] TOP_IDX = 5'(BITS - 1);
    localparam logic [4:0] WORD_LEN = 5'(BITS);

    // ==========================================
    // pin synchronisers
    logic [`SYNC_WIDTH-1:0] pins_s;
    logic conv_d1_q;
    logic sclk_d1_q;

    sync_bank #(.W(`SYNC_WIDTH)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .d_in({convert_strobe_in, chain_select_in,
               read_enable_or_chain_input_in, sclk_in}),
        .q_out(pins_s)
    );

    wire conv_s = pins_s[3];
    wire chain_s = pins_s[2];
    wire shared_s = pins_s[1];
    wire sclk_s = pins_s[0];
    wire conv_rise = conv_s && !conv_d1_q;
    wire sclk_rise = sclk_s && !sclk_d1_q;

    // edge detectors read the synchronised copies only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            conv_d1_q <= 1'b0;
            sclk_d1_q <= 1'b0;
        end else begin
            conv_d1_q <= conv_s;
            sclk_d1_q <= sclk_s;
        end
    end

    // ==========================================
    // conversion sequencer
    sar_adc_pkg::conv_state_e st_q;
    sar_adc_pkg::conv_state_e st_d;
    logic [4:0] tmr_q;
    logic [4:0] idx_q;
    logic sar_done_q;
    logic [BITS-1:0] code_q;
    logic busy_q;
    logic pwr_q;
    logic sample_q;
    logic fifo_wr_ready;

    // strobe edges during a conversion are ignored
    wire start = (st_q == sar_adc_pkg::ST_ACQ) && conv_rise;
    wire sar_step = (st_q == sar_adc_pkg::ST_CONV) && !sar_done_q;
    wire timer_end = tmr_q >= CONV_LEN - 5'h01;
    // a full fifo holds busy high: back-pressure onto the host
    wire finish = (st_q == sar_adc_pkg::ST_WAIT) && fifo_wr_ready;
    wire [BITS-1:0] bit_mask = BITS'(1) << idx_q;
    wire [BITS-1:0] lower_mask = bit_mask >> 1;
    // keep the trial bit on a high comparator, then try the next lower one
    wire [BITS-1:0] code_next =
        (comparator_in ? code_q : (code_q & ~bit_mask)) | lower_mask;

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            sar_adc_pkg::ST_ACQ: begin
                if (start) begin
                    st_d = sar_adc_pkg::ST_CONV;
                end
            end
            sar_adc_pkg::ST_CONV: begin
                if (timer_end && sar_done_q) begin
                    st_d = sar_adc_pkg::ST_WAIT;
                end
            end
            sar_adc_pkg::ST_WAIT: begin
                if (fifo_wr_ready) begin
                    st_d = sar_adc_pkg::ST_ACQ;
                end
            end
            default: begin
                st_d = sar_adc_pkg::ST_ACQ;
            end
        endcase
    end

    // state, timer, busy and power
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= sar_adc_pkg::ST_ACQ;
            tmr_q <= 5'h00;
            busy_q <= 1'b0;
            pwr_q <= 1'b0;
            sample_q <= 1'b1;
        end else begin
            st_q <= st_d;
            tmr_q <= start ? 5'h00 : (timer_end ? tmr_q : tmr_q + 5'h01);
            busy_q <= start || (busy_q && !finish);
            pwr_q <= start || (pwr_q && !finish);
            // own flop so the switch output carries no gate after the register
            sample_q <= !(start || (busy_q && !finish));
        end
    end

    // successive approximation register, one decision per cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            code_q <= '0;
            idx_q <= 5'h00;
            sar_done_q <= 1'b0;
        end else if (start) begin
            code_q <= BITS'(1) << TOP_IDX;
            idx_q <= TOP_IDX;
            sar_done_q <= 1'b0;
        end else if (sar_step) begin
            code_q <= code_next;
            idx_q <= (idx_q == 5'h00) ? 5'h00 : idx_q - 5'h01;
            sar_done_q <= idx_q == 5'h00;
        end
    end

    // ==========================================
    // result buffer
    logic fifo_rd_valid;
    logic [BITS-1:0] fifo_rd_data;
    logic load;

    // code is plain unsigned binary, pushed as it stands
    result_fifo #(.WIDTH(BITS), .DEPTH(DEPTH)) u_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .wr_valid_in(st_q == sar_adc_pkg::ST_WAIT),
        .wr_ready_out(fifo_wr_ready),
        .wr_data_in(code_q),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in(load),
        .rd_data_out(fifo_rd_data)
    );

    // ==========================================
    // serial readout
    logic [BITS-1:0] shift_q;
    logic [4:0] left_q;
    logic armed_q;
    logic oe_q;

    // normal mode: shared pin low enables; chain mode: always driving
    wire oe_d = chain_s || !shared_s;
    wire chain_bit = chain_s ? shared_s : 1'b0;
    // reload only once per conversion, after the previous word left
    wire drained = left_q == 5'h00;
    assign load = fifo_rd_valid && drained && armed_q;
    wire shift = sclk_rise && oe_q && !load;

    // arm on every start; a new start beats the clear of a load
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= start || (armed_q && !load);
        end
    end

    // shifter: msb sits on the output, chain bits enter at the bottom
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_q <= '0;
            left_q <= 5'h00;
        end else if (load) begin
            shift_q <= fifo_rd_data;
            left_q <= WORD_LEN;
        end else if (shift) begin
            shift_q <= {shift_q[BITS-2:0], chain_bit};
            left_q <= drained ? 5'h00 : left_q - 5'h01;
        end
    end

    // enable register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    // outputs straight from flops
    assign busy_out = busy_q;
    assign sdo_out = shift_q[BITS-1];
    assign sdo_oe_out = oe_q;
    assign sampling_cap_dac_out = code_q;
    assign sample_out = sample_q;
    assign powered_up_out = pwr_q;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_busy_start;
        start |=> busy_out && powered_up_out;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised");

    property p_busy_hold;
        $rose(busy_out) |-> busy_out [*8] ##15 busy_out;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

    property p_busy_end;
        (st_q == sar_adc_pkg::ST_CONV) && fifo_wr_ready && !start
            ##0 (timer_end && sar_done_q) ##1 fifo_wr_ready |=> !busy_out;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy stuck");

    property p_sar_len;
        $rose(busy_out) |-> !sar_done_q [*8] ##11 sar_done_q;
    endproperty
    a_sar_len: assert property (p_sar_len) else $error("sar step count");

    property p_power_down;
        $fell(busy_out) |-> !powered_up_out && sample_out;
    endproperty
    a_power_down: assert property (p_power_down) else $error("no power down");

    property p_oe_normal;
        !chain_s && !shared_s |=> sdo_oe_out;
    endproperty
    a_oe_normal: assert property (p_oe_normal) else $error("enable ignored");

    property p_oe_off;
        !chain_s && shared_s |=> !sdo_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("disable ignored");

    property p_oe_chain;
        chain_s |=> sdo_oe_out;
    endproperty
    a_oe_chain: assert property (p_oe_chain) else $error("chain not driving");

    property p_shift;
        shift |=> sdo_out == $past(shift_q[BITS-2]);
    endproperty
    a_shift: assert property (p_shift) else $error("bad next bit");

    property p_load;
        load |=> shift_q == $past(fifo_rd_data) && left_q == WORD_LEN;
    endproperty
    a_load: assert property (p_load) else $error("load lost");

    property p_forward;
        shift && chain_s |=> shift_q[0] == $past(shared_s);
    endproperty
    a_forward: assert property (p_forward) else $error("chain bit lost");

    c_conversion: cover property ($rose(busy_out) ##[20:40] $fell(busy_out));
    c_forward: cover property (shift && chain_s && drained);
    c_fifo_full: cover property (!fifo_wr_ready);
    c_word_out: cover property (load ##[1:400] (shift && left_q == 5'h01));
endmodule

// [dv/adc_host_model.sv]
// Purpose: host and analog front end facing the converter
// Assumes: clk_in is the 50 MHz core clock; serial clock period is 8 cycles
// Notes: comparator answers at once from the trial code; sclk idles low
`timescale 1ns/1ps

// ==========================================
// host model
module adc_host_model (
    input wire logic clk_in, // core clock
    input wire logic busy_in, // conversion running
    input wire logic sdo_in, // serial data
    input wire logic oe_in, // serial data driven
    input wire logic pwr_in, // core powered
    input wire logic smp_in, // acquisition switch
    input wire logic [17:0] dac_in, // trial code
    output logic strobe_out, // conversion start
    output logic chain_sel_out, // mode pin
    output logic shared_out, // enable or chain data
    output logic sclk_out, // serial clock
    output logic cmp_out // comparator decision
);
    logic [17:0] analog_q;
    time t_start;
    // ideal comparator; the held sample never moves during a conversion
    assign cmp_out = (analog_q >= dac_in);
    // idle levels at time zero
    initial begin
        strobe_out = 1'b0;
        chain_sel_out = 1'b0;
        shared_out = 1'b1;
        sclk_out = 1'b0;
        analog_q = 18'h00000;
        t_start = 0;
    end
    // no start before the converter has reinitialised
    task automatic por_wait();
        repeat (1000) @(posedge clk_in);
    endtask
    // mode change; normal mode leaves the output disabled
    task automatic set_mode(input logic ch);
        @(posedge clk_in);
        chain_sel_out <= ch;
        shared_out <= ~ch;
        repeat (4) @(posedge clk_in);
    endtask
    // one start edge; again puts a stray edge in mid conversion
    task automatic convert(input logic [17:0] code, input logic again, output int len,
                           output logic pwr, output logic smp);
        len = 0;
        pwr = 1'b0;
        smp = 1'b1;
        while ($time - t_start < 1000) @(posedge clk_in);
        @(posedge clk_in);
        analog_q <= code;
        strobe_out <= 1'b1;
        t_start = $time;
        repeat (10) begin
            @(negedge clk_in);
            if (busy_in === 1'b1) break;
        end
        while (busy_in === 1'b1 && len < 60) begin
            if (len == 10) begin
                pwr = pwr_in;
                smp = smp_in;
            end
            len++;
            @(posedge clk_in);
            strobe_out <= again && len > 5 && len < 9;
            @(negedge clk_in);
        end
    endtask
    // enables output, waits 6 cycles, then 36 edges: own word and, in chain mode, one forwarded word
    task automatic read_out(input logic [17:0] up, output logic [35:0] got,
                            output logic oe, output logic stray);
        got = '0;
        stray = 1'b0;
        @(posedge clk_in);
        if (!chain_sel_out) shared_out <= 1'b0;
        repeat (6) @(negedge clk_in);
        oe = oe_in;
        for (int i = 0; i < 36; i++) begin
            @(posedge clk_in);
            sclk_out <= 1'b0;
            // past its word the upstream line toggles, never holds
            if (chain_sel_out) shared_out <= (i < 18) ? up[17 - i] : ~shared_out;
            repeat (4) @(negedge clk_in);
            got = {got[34:0], sdo_in};
            stray |= busy_in;
            @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        sclk_out <= 1'b0;
        shared_out <= chain_sel_out ? ~shared_out : 1'b1;
    endtask
endmodule

// [dv/test_sar_adc_readout.sv]
// Purpose: self-checking bench for the converter control and readout
// Assumes: 50 MHz core clock, 160 ns serial clock
// Notes: random codes from a fixed seed, corner codes first
`timescale 1ns/1ps

// ==========================================
// bench top
module test_sar_adc_readout;
    localparam logic [17:0] CORNER [4] = '{18'h00000, 18'h3FFFF, 18'h20000, 18'h1FFFF};
    logic clk_in;
    logic resetn_in;
    logic strobe, chain_sel, shared, sclk, cmp;
    logic busy, sdo, sdo_oe, smp, pwr;
    logic [17:0] dac;
    int fails;
    int tests_run;

    sar_adc_readout #(.BITS(18), .DEPTH(8)) sar_adc_readout_i (
        .clk_in(clk_in), .resetn_in(resetn_in), .convert_strobe_in(strobe),
        .chain_select_in(chain_sel), .read_enable_or_chain_input_in(shared),
        .sclk_in(sclk), .comparator_in(cmp), .busy_out(busy), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .sampling_cap_dac_out(dac), .sample_out(smp),
        .powered_up_out(pwr)
    );
    adc_host_model adc_host_model_i (
        .clk_in(clk_in), .busy_in(busy), .sdo_in(sdo), .oe_in(sdo_oe), .pwr_in(pwr),
        .smp_in(smp), .dac_in(dac), .strobe_out(strobe), .chain_sel_out(chain_sel),
        .shared_out(shared), .sclk_out(sclk), .cmp_out(cmp)
    );

    // ==========================================
    // clock, compare and verdict
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // own word first, then the upstream word or zeros in normal mode
    function automatic logic [35:0] expect_stream(input logic ch, input logic [17:0] c,
                                                  input logic [17:0] u);
        return {c, ch ? u : 18'h00000};
    endfunction

    // ==========================================
    // scenarios
    task automatic reset_pulse();
        resetn_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        @(negedge clk_in);
        check("reset outputs", {busy, sdo, sdo_oe, dac, smp, pwr}, {21'h000000, 2'h2});
        @(posedge clk_in);
        resetn_in <= 1'b1;
        adc_host_model_i.por_wait();
    endtask
    task automatic run_one(input logic [17:0] c, input logic ch, input logic again);
        logic [17:0] u;
        logic [35:0] got;
        logic p_mid, s_mid, oe, stray;
        int len;
        u = 18'($urandom);
        adc_host_model_i.set_mode(ch);
        adc_host_model_i.convert(c, again, len, p_mid, s_mid);
        check("busy length", len >= 24 && len <= 25, 1'b1);
        check("powered in conversion", {p_mid, s_mid}, 2'h2);
        adc_host_model_i.read_out(u, got, oe, stray);
        check("output enable", oe, 1'b1);
        check("no restart", stray, 1'b0);
        check("serial stream", got, expect_stream(ch, c, u));
        repeat (6) @(negedge clk_in);
        check("enable released", sdo_oe, ch);
        check("powered down", {pwr, smp}, 2'h1);
    endtask

    // watchdog well past the expected 0.2 ms run
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
    // main sequence: corners, random codes, a second reset, more codes
    initial begin
        fails = 0;
        tests_run = 0;
        resetn_in = 1'b0;
        void'($urandom(32'hAF57));
        reset_pulse();
        for (int k = 0; k < 4; k++) run_one(CORNER[k], 1'(k % 2), k == 1);
        repeat (16) run_one(18'($urandom), 1'($urandom), 1'($urandom));
        reset_pulse();
        repeat (2) run_one(18'($urandom), 1'($urandom), 1'b0);
        give_verdict();
    end
endmodule
